// ### hw/dcir_cfg.svh
// Functional notes
// - Accept 168 sources, offered to both cores
// - Main core line n is source n
// - Secondary core has eight mapped request lines
// - Secondary core has eight software-only interrupts
// - Priorities: eight levels main, four secondary
// - Four selectable NMI sources per core
// - 39 sources can wake from deep sleep
// - Each core has own controller and waker
// - Sixteen channels and sixteen interrupt structures
// - Every channel carries a claim/release lock
// - Interrupt structures let one core interrupt other
// - Notify and release raise structure events
`ifndef DCIR_CFG_SVH
`define DCIR_CFG_SVH
// Sizes
`define DCIR_NSRC 168
`define DCIR_NLINE 8
`define DCIR_MAP_W 192
`define DCIR_NWORD 3'h6
`define DCIR_NCH 16
`define DCIR_NWAKE 39
`define DCIR_NNMI 4
`define DCIR_PRIO_W 3
`define DCIR_NOTE_LSB 16
`define DCIR_ZERO 32'h0000_0000
// Event status bits
`define DCIR_EV_BUSY 0
`define DCIR_EV_FREE 1
// Plain register byte addresses
`define DCIR_A_EVT_STAT 12'h004
`define DCIR_A_EVT_MASK 12'h008
`define DCIR_A_SEC_SWI 12'h00C
`define DCIR_A_SEC_PRIO 12'h010
`define DCIR_A_NMI_MAIN 12'h014
`define DCIR_A_NMI_SEC 12'h018
`define DCIR_A_NMI_EN 12'h01C
`define DCIR_A_WAKE_M0 12'h020
`define DCIR_A_WAKE_M1 12'h024
`define DCIR_A_WAKE_S0 12'h028
`define DCIR_A_WAKE_S1 12'h02C
`define DCIR_A_LOCK 12'h030
// Address fields and region codes
`define DCIR_F_MAP 11:8
`define DCIR_R_MAP 4'h1
`define DCIR_F_LINE 7:5
`define DCIR_F_WORD 4:2
`define DCIR_F_IPC 11:6
`define DCIR_R_DATA 6'h08
`define DCIR_R_ACQ 6'h09
`define DCIR_R_REL 6'h0A
`define DCIR_R_NOTE 6'h0B
`define DCIR_F_CH 5:2
`define DCIR_F_STR 11:7
`define DCIR_R_STR 5'h06
`define DCIR_F_SIDX 6:3
`define DCIR_F_SREG 2
`define DCIR_F_PRIO 11:10
`define DCIR_R_PRIO 2'h1
`define DCIR_F_PIDX 9:2
`endif

// ### hw/dcir_pkg.sv
package dcir_pkg;
    // Wishbone slave phases: request seen, answer prepared, ack shown
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_ACK = 2'b10
    } dcir_bus_st_t;
    // One bus request as the slave sees it
    typedef struct packed {
        logic we;
        logic [11:0] adr;
        logic [31:0] dat;
        logic [31:0] msk;
    } dcir_wb_req_t;
    // A level for each core
    typedef struct packed {
        logic main;
        logic sec;
    } dcir_core_pair_t;
endpackage

// ### hw/dcir_prio_mem.sv
`include "dcir_cfg.svh"
module dcir_prio_mem (
    input wire logic clk,
    input wire logic rstn,
    input wire logic a_we,
    input wire logic [7:0] a_addr,
    input wire logic [`DCIR_PRIO_W-1:0] a_wdata,
    output logic [`DCIR_PRIO_W-1:0] a_rdata,
    input wire logic [7:0] b_addr,
    output logic [`DCIR_PRIO_W-1:0] b_rdata
);
    // Main core priority per source, eight levels each
    logic [`DCIR_PRIO_W-1:0] mem [`DCIR_NSRC];
    logic a_ok; // Address inside the table
    logic b_ok;
    assign a_ok = a_addr < 8'(`DCIR_NSRC);
    assign b_ok = b_addr < 8'(`DCIR_NSRC);

    // Table update; reset gives every source the top level
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < `DCIR_NSRC; i++) begin
                mem[i] <= '0;
            end
        end else if (a_we && a_ok) begin
            mem[a_addr] <= a_wdata;
        end
    end

    // Registered reads; outside the table reads as zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            a_rdata <= '0;
            b_rdata <= '0;
        end else begin
            a_rdata <= a_ok ? mem[a_addr] : '0;
            b_rdata <= b_ok ? mem[b_addr] : '0;
        end
    end

    // A written level is seen on the query port two edges later,
    // provided the query index has not moved meanwhile
    property p_prio_rd;
        @(posedge clk) disable iff (!rstn)
        (a_we && a_ok && b_addr == a_addr)
            ##1 (!a_we && b_addr == $past(b_addr))
        |=> b_rdata == $past(a_wdata, 2);
    endproperty
    a_prio_rd: assert property (p_prio_rd)
        else $error("priority table lost a write");
endmodule

// ### hw/dcir_sec_mux.sv
`include "dcir_cfg.svh"
module dcir_sec_mux (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [`DCIR_NSRC-1:0] src,
    input wire logic [`DCIR_NLINE-1:0][`DCIR_NSRC-1:0] map,
    output logic [`DCIR_NLINE-1:0] irq
);
    // One OR tree per secondary line; no register so the level
    // follows the sources with no added latency
    genvar l;
    generate
        for (l = 0; l < `DCIR_NLINE; l++) begin : g_line
            assign irq[l] = |(src & map[l]);
        end
    endgenerate

    // Line 0 only rises when some source it maps is high
    property p_sec_or;
        @(posedge clk) disable iff (!rstn)
        irq[0] |-> (src & map[0]) != '0;
    endproperty
    a_sec_or: assert property (p_sec_or)
        else $error("secondary line high with no mapped source");

    // An empty map keeps every line quiet
    property p_sec_idle;
        @(posedge clk) disable iff (!rstn)
        map == '0 |-> irq == '0;
    endproperty
    a_sec_idle: assert property (p_sec_idle)
        else $error("unmapped secondary line asserted");
endmodule

// ### hw/dcir_top.sv
`include "dcir_cfg.svh"
module dcir_top (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [`DCIR_NSRC-1:0] SRC_IRQ,
    output logic [`DCIR_NSRC-1:0] MAIN_IRQ,
    output logic [`DCIR_NLINE-1:0] SEC_IRQ,
    output logic [`DCIR_NLINE-1:0] SEC_SWI,
    output logic [31:0] SEC_PRIO,
    input wire logic [7:0] MAIN_PRIO_IDX,
    output logic [`DCIR_PRIO_W-1:0] MAIN_PRIO,
    output logic MAIN_NMI,
    output logic SEC_NMI,
    input wire logic MAIN_DEEP_SLEEP,
    input wire logic SEC_DEEP_SLEEP,
    output logic MAIN_WAKE,
    output logic SEC_WAKE,
    output logic [`DCIR_NCH-1:0] IPC_IRQ,
    output logic INT
);
    dcir_pkg::dcir_wb_req_t req; // Current bus request
    dcir_pkg::dcir_bus_st_t st; // Slave phase
    dcir_pkg::dcir_bus_st_t next_st;
    dcir_pkg::dcir_core_pair_t wake; // Per-core wake levels
    logic wr_go; // Write commits at the acked edge
    logic rd_go; // Read side effects at the answer edge
    logic [3:0] ch; // Channel addressed
    logic [15:0] ch_hot;
    logic [3:0] sidx; // Interrupt structure addressed
    logic [5:0] ipc_reg; // INTERPROC_CHANNEL_BLOCK region code
    logic hit_map; // Secondary map window
    logic hit_prio; // Main priority window
    logic acq_go; // Lock acquire read
    logic rel_go; // Channel release write
    logic note_go; // Channel notify write
    logic [31:0] rd; // Read mux
    logic [`DCIR_PRIO_W-1:0] prio_rd;
    // Software registers
    logic [`DCIR_MAP_W-1:0] sec_map [`DCIR_NLINE];
    logic [`DCIR_NLINE-1:0][`DCIR_NSRC-1:0] map_v;
    logic [31:0] sec_swi;
    logic [31:0] sec_prio;
    logic [31:0] nmi_main; // Four 8-bit source numbers
    logic [31:0] nmi_sec;
    logic [31:0] nmi_en; // Low nibble main, next nibble secondary
    logic [31:0] wake_m0;
    logic [31:0] wake_m1;
    logic [31:0] wake_s0;
    logic [31:0] wake_s1;
    logic [31:0] evt_stat;
    logic [31:0] evt_mask;
    logic [31:0] ipc_data [`DCIR_NCH];
    logic [`DCIR_NCH-1:0] lock;
    logic [31:0] ipc_stat [`DCIR_NCH];
    logic [31:0] ipc_mask [`DCIR_NCH];
    logic [`DCIR_NNMI-1:0] nmi_hit_m;
    logic [`DCIR_NNMI-1:0] nmi_hit_s;

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [31:0] m);
        return (old & ~m) | (d & m);
    endfunction

    // Gather the request and widen the byte enables
    always_comb begin
        req.we = WB_WE_I;
        req.adr = WB_ADR_I;
        req.dat = WB_DAT_I;
        for (int b = 0; b < 4; b++) begin
            req.msk[b*8 +: 8] = {8{WB_SEL_I[b]}};
        end
    end

    // Decode
    assign ch = req.adr[`DCIR_F_CH];
    assign ch_hot = 16'h0001 << ch;
    assign sidx = req.adr[`DCIR_F_SIDX];
    assign ipc_reg = req.adr[`DCIR_F_IPC];
    assign hit_map = req.adr[`DCIR_F_MAP] == `DCIR_R_MAP
        && req.adr[`DCIR_F_WORD] < `DCIR_NWORD;
    assign hit_prio = req.adr[`DCIR_F_PRIO] == `DCIR_R_PRIO;
    assign wr_go = st == dcir_pkg::BUS_ACK && WB_CYC_I && WB_STB_I
        && req.we;
    assign rd_go = st == dcir_pkg::BUS_WAIT && !req.we;
    assign acq_go = rd_go && ipc_reg == `DCIR_R_ACQ;
    assign rel_go = wr_go && ipc_reg == `DCIR_R_REL;
    assign note_go = wr_go && ipc_reg == `DCIR_R_NOTE;

    // Phase sequencer: answer always two edges after the request
    always_comb begin
        case (st)
            dcir_pkg::BUS_IDLE: next_st = (WB_CYC_I && WB_STB_I)
                ? dcir_pkg::BUS_WAIT : dcir_pkg::BUS_IDLE;
            dcir_pkg::BUS_WAIT: next_st = dcir_pkg::BUS_ACK;
            default: next_st = dcir_pkg::BUS_IDLE;
        endcase
    end
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            st <= dcir_pkg::BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end
    assign WB_ACK_O = st == dcir_pkg::BUS_ACK;

    // Plain control registers
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            sec_swi <= `DCIR_ZERO;
            sec_prio <= `DCIR_ZERO;
            nmi_main <= `DCIR_ZERO;
            nmi_sec <= `DCIR_ZERO;
            nmi_en <= `DCIR_ZERO;
            wake_m0 <= `DCIR_ZERO;
            wake_m1 <= `DCIR_ZERO;
            wake_s0 <= `DCIR_ZERO;
            wake_s1 <= `DCIR_ZERO;
            evt_mask <= `DCIR_ZERO;
        end else if (wr_go) begin
            case (req.adr)
                `DCIR_A_SEC_SWI: begin
                    sec_swi <= merge(sec_swi, req.dat, req.msk);
                end
                `DCIR_A_SEC_PRIO: begin
                    sec_prio <= merge(sec_prio, req.dat, req.msk);
                end
                `DCIR_A_NMI_MAIN: begin
                    nmi_main <= merge(nmi_main, req.dat, req.msk);
                end
                `DCIR_A_NMI_SEC: begin
                    nmi_sec <= merge(nmi_sec, req.dat, req.msk);
                end
                `DCIR_A_NMI_EN: begin
                    nmi_en <= merge(nmi_en, req.dat, req.msk);
                end
                `DCIR_A_WAKE_M0: begin
                    wake_m0 <= merge(wake_m0, req.dat, req.msk);
                end
                `DCIR_A_WAKE_M1: begin
                    wake_m1 <= merge(wake_m1, req.dat, req.msk);
                end
                `DCIR_A_WAKE_S0: begin
                    wake_s0 <= merge(wake_s0, req.dat, req.msk);
                end
                `DCIR_A_WAKE_S1: begin
                    wake_s1 <= merge(wake_s1, req.dat, req.msk);
                end
                `DCIR_A_EVT_MASK: begin
                    evt_mask <= merge(evt_mask, req.dat, req.msk);
                end
                default: begin
                end
            endcase
        end
    end
    assign SEC_SWI = sec_swi[`DCIR_NLINE-1:0];
    assign SEC_PRIO = sec_prio;

    // Map words, channel data and interrupt structures, one per entry
    genvar g;
    generate
        for (g = 0; g < `DCIR_NLINE; g++) begin : g_map
            always_ff @(posedge CLK_SYS) begin
                if (!RSTN) begin
                    sec_map[g] <= '0;
                end else if (wr_go && hit_map
                             && req.adr[`DCIR_F_LINE] == g) begin
                    sec_map[g][{req.adr[`DCIR_F_WORD], 5'h00} +: 32]
                        <= merge(sec_map[g][{req.adr[`DCIR_F_WORD],
                                 5'h00} +: 32], req.dat, req.msk);
                end
            end
            assign map_v[g] = sec_map[g][`DCIR_NSRC-1:0];
        end
        for (g = 0; g < `DCIR_NCH; g++) begin : g_ipc
            // Channel data word
            always_ff @(posedge CLK_SYS) begin
                if (!RSTN) begin
                    ipc_data[g] <= `DCIR_ZERO;
                end else if (wr_go && ipc_reg == `DCIR_R_DATA
                             && ch == g) begin
                    ipc_data[g] <= merge(ipc_data[g], req.dat,
                                         req.msk);
                end
            end
            // Structure g: release events low half, notify high half;
            // a new event beats a clear in the same cycle
            always_ff @(posedge CLK_SYS) begin
                if (!RSTN) begin
                    ipc_stat[g] <= `DCIR_ZERO;
                    ipc_mask[g] <= `DCIR_ZERO;
                end else begin
                    ipc_stat[g] <= (ipc_stat[g]
                        & ~((wr_go && req.adr[`DCIR_F_STR] == `DCIR_R_STR
                             && sidx == g && !req.adr[`DCIR_F_SREG])
                            ? (req.dat & req.msk) : `DCIR_ZERO))
                        | ((rel_go && req.dat[g])
                            ? {16'h0000, ch_hot} : `DCIR_ZERO)
                        | ((note_go && req.dat[g])
                            ? {ch_hot, 16'h0000} : `DCIR_ZERO);
                    if (wr_go && req.adr[`DCIR_F_STR] == `DCIR_R_STR
                        && sidx == g && req.adr[`DCIR_F_SREG]) begin
                        ipc_mask[g] <= merge(ipc_mask[g], req.dat,
                                             req.msk);
                    end
                end
            end
            assign IPC_IRQ[g] = |(ipc_stat[g] & ipc_mask[g]);
        end
        // NMI slots: an enabled slot passes its chosen source
        for (g = 0; g < `DCIR_NNMI; g++) begin : g_nmi
            assign nmi_hit_m[g] = nmi_en[g]
                && nmi_main[g*8 +: 8] < 8'(`DCIR_NSRC)
                && SRC_IRQ[nmi_main[g*8 +: 8]];
            assign nmi_hit_s[g] = nmi_en[g + `DCIR_NNMI]
                && nmi_sec[g*8 +: 8] < 8'(`DCIR_NSRC)
                && SRC_IRQ[nmi_sec[g*8 +: 8]];
        end
    endgenerate
    assign MAIN_NMI = |nmi_hit_m;
    assign SEC_NMI = |nmi_hit_s;

    // Lock: the read that finds it free takes it in the same edge,
    // so two contending cores can never both win
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            lock <= '0;
        end else if (acq_go) begin
            lock[ch] <= 1'b1;
        end else if (rel_go) begin
            lock[ch] <= 1'b0;
        end
    end

    // Sticky block events, write one to clear, set wins
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            evt_stat <= `DCIR_ZERO;
        end else begin
            evt_stat <= (evt_stat & ~((wr_go
                && req.adr == `DCIR_A_EVT_STAT)
                ? (req.dat & req.msk) : `DCIR_ZERO))
                | ((acq_go && lock[ch])
                    ? (32'h0000_0001 << `DCIR_EV_BUSY) : `DCIR_ZERO)
                | ((rel_go && !lock[ch])
                    ? (32'h0000_0001 << `DCIR_EV_FREE) : `DCIR_ZERO);
        end
    end
    assign INT = |(evt_stat & evt_mask);

    // Main core lines pass straight through, one per source
    assign MAIN_IRQ = SRC_IRQ;

    dcir_sec_mux u_sec_mux (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .src(SRC_IRQ),
        .map(map_v),
        .irq(SEC_IRQ)
    );

    dcir_prio_mem u_prio_mem (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .a_we(wr_go && hit_prio && WB_SEL_I[0]),
        .a_addr(req.adr[`DCIR_F_PIDX]),
        .a_wdata(req.dat[`DCIR_PRIO_W-1:0]),
        .a_rdata(prio_rd),
        .b_addr(MAIN_PRIO_IDX),
        .b_rdata(MAIN_PRIO)
    );

    // Wake only the sleeping core; first sources are wake capable
    assign wake.main = MAIN_DEEP_SLEEP && |(SRC_IRQ[`DCIR_NWAKE-1:0]
        & {wake_m1[`DCIR_NWAKE-33:0], wake_m0});
    assign wake.sec = SEC_DEEP_SLEEP && |(SRC_IRQ[`DCIR_NWAKE-1:0]
        & {wake_s1[`DCIR_NWAKE-33:0], wake_s0});
    assign MAIN_WAKE = wake.main;
    assign SEC_WAKE = wake.sec;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd = `DCIR_ZERO;
        if (hit_map) begin
            rd = sec_map[req.adr[`DCIR_F_LINE]]
                [{req.adr[`DCIR_F_WORD], 5'h00} +: 32];
        end else if (hit_prio) begin
            rd = {29'h0000_0000, prio_rd};
        end else if (ipc_reg == `DCIR_R_DATA) begin
            rd = ipc_data[ch];
        end else if (ipc_reg == `DCIR_R_ACQ) begin
            rd = {31'h0000_0000, !lock[ch]};
        end else if (req.adr[`DCIR_F_STR] == `DCIR_R_STR) begin
            rd = req.adr[`DCIR_F_SREG] ? ipc_mask[sidx] : ipc_stat[sidx];
        end else begin
            case (req.adr)
                `DCIR_A_EVT_STAT: rd = evt_stat;
                `DCIR_A_EVT_MASK: rd = evt_mask;
                `DCIR_A_SEC_SWI: rd = sec_swi;
                `DCIR_A_SEC_PRIO: rd = sec_prio;
                `DCIR_A_NMI_MAIN: rd = nmi_main;
                `DCIR_A_NMI_SEC: rd = nmi_sec;
                `DCIR_A_NMI_EN: rd = nmi_en;
                `DCIR_A_WAKE_M0: rd = wake_m0;
                `DCIR_A_WAKE_M1: rd = wake_m1;
                `DCIR_A_WAKE_S0: rd = wake_s0;
                `DCIR_A_WAKE_S1: rd = wake_s1;
                `DCIR_A_LOCK: rd = {16'h0000, lock};
                default: rd = `DCIR_ZERO;
            endcase
        end
    end

    // Read data is captured while preparing the answer
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            WB_DAT_O <= `DCIR_ZERO;
        end else if (rd_go) begin
            WB_DAT_O <= rd;
        end
    end

    // Bus answer timing
    sequence s_start;
        st == dcir_pkg::BUS_IDLE && WB_CYC_I && WB_STB_I;
    endsequence
    sequence s_answer;
        !WB_ACK_O ##1 WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    property p_ack_lat;
        @(posedge CLK_SYS) disable iff (!RSTN)
        s_start |=> s_answer;
    endproperty
    a_ack_lat: assert property (p_ack_lat)
        else $error("ack not two edges after request");

    property p_lock_take;
        @(posedge CLK_SYS) disable iff (!RSTN)
        acq_go && !lock[ch] |=> lock[$past(ch)] && WB_DAT_O[0];
    endproperty
    a_lock_take: assert property (p_lock_take)
        else $error("free lock not taken by acquire");

    property p_lock_refuse;
        @(posedge CLK_SYS) disable iff (!RSTN)
        acq_go && lock[ch] |=> !WB_DAT_O[0] && evt_stat[`DCIR_EV_BUSY];
    endproperty
    a_lock_refuse: assert property (p_lock_refuse)
        else $error("held lock granted twice");

    // Watched on structure 14, one that applications may use
    property p_release;
        @(posedge CLK_SYS) disable iff (!RSTN)
        rel_go && req.dat[14] |=> !lock[$past(ch)]
            && ipc_stat[14][$past(ch)];
    endproperty
    a_release: assert property (p_release)
        else $error("release left lock or raised no event");

    property p_notify;
        @(posedge CLK_SYS) disable iff (!RSTN)
        note_go && req.dat[14] && ipc_mask[14][`DCIR_NOTE_LSB + ch]
        |=> IPC_IRQ[14];
    endproperty
    a_notify: assert property (p_notify)
        else $error("unmasked notify raised no interrupt");

    property p_swi;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_go && req.adr == `DCIR_A_SEC_SWI && WB_SEL_I[0]
        |=> SEC_SWI == $past(req.dat[`DCIR_NLINE-1:0]);
    endproperty
    a_swi: assert property (p_swi)
        else $error("software interrupt write lost");

    property p_nmi_off;
        @(posedge CLK_SYS) disable iff (!RSTN)
        nmi_en == `DCIR_ZERO |-> !MAIN_NMI && !SEC_NMI;
    endproperty
    a_nmi_off: assert property (p_nmi_off)
        else $error("NMI with no slot enabled");

    property p_wake;
        @(posedge CLK_SYS) disable iff (!RSTN)
        !MAIN_DEEP_SLEEP |-> !MAIN_WAKE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake raised for an awake core");
endmodule

// ### test/dcir_src_model.sv
// Peripheral side: holds the source levels that feed the router
module dcir_src_model (
    input wire logic clk,
    input wire logic load,
    input wire logic [31:0] seed,
    output logic [167:0] src
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels change only on a load, never in mid-check; one process
    // both clears and loads, so the pattern has a single driver
    initial begin
        src = '0;
        forever begin
            @(posedge clk);
            if (load) begin
                src <= {seed[7:0], {4{seed ^ 32'h5A5A_A5A5}}, seed};
            end
        end
    end
endmodule

// ### test/dcir_test.sv
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module dual_cpu_interrupt_routing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, load = 0;
    logic m_slp = 0, s_slp = 0, ack, m_nmi, s_nmi, m_wake, s_wake, int_o;
    logic [11:0] adr = '0;
    logic [31:0] dat = '0, rdo, rd, s_prio, seed = 32'h0000_0063;
    logic [3:0] sel = '0;
    logic [7:0] idx = '0, s_irq, s_swi;
    logic [167:0] src, m_irq;
    logic [2:0] m_prio;
    logic [15:0] interproc_channel_block;
    int error_cnt = 0, comparisons = 0;
    // Free-running system clock, 8 ns period
    always #4 clk = ~clk;
    dcir_src_model PERIPH (.clk(clk), .load(load), .seed(seed), .src(src));
    dcir_top DUT (.CLK_SYS(clk), .RSTN(rstn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat),
        .WB_SEL_I(sel), .WB_DAT_O(rdo), .WB_ACK_O(ack), .SRC_IRQ(src),
        .MAIN_IRQ(m_irq), .SEC_IRQ(s_irq), .SEC_SWI(s_swi),
        .SEC_PRIO(s_prio), .MAIN_PRIO_IDX(idx), .MAIN_PRIO(m_prio),
        .MAIN_NMI(m_nmi), .SEC_NMI(s_nmi), .MAIN_DEEP_SLEEP(m_slp),
        .SEC_DEEP_SLEEP(s_slp), .MAIN_WAKE(m_wake), .SEC_WAKE(s_wake),
        .IPC_IRQ(interproc_channel_block), .INT(int_o));
    // Pseudo-random step for source patterns
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Classic single cycle; only the watchdog ends a hung wait
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Read and compare in one step
    task automatic rdchk(input string n, input logic [11:0] a,
                         input logic [31:0] e);
        wb(1'b0, a, '0);
        `CHK(n, e, rd)
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog: the whole run needs far fewer than 20000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK("int_rst", 1'b0, int_o)
        `CHK("sec_rst", 8'h00, s_irq)
        // Source 37 onto secondary line 3 (line kept clear of system use)
        wb(1'b1, 12'h164, 32'h0000_0020);
        wb(1'b1, 12'h014, 32'h0000_0005);
        wb(1'b1, 12'h018, 32'h0000_0009);
        wb(1'b1, 12'h01C, 32'h0000_0011);
        wb(1'b1, 12'h024, 32'h0000_0040);
        wb(1'b1, 12'h028, 32'h0000_0001);
        // Random source levels with sleep toggling
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            seed <= lfsr(seed);
            load <= 1'b1;
            m_slp <= seed[0];
            s_slp <= seed[1];
            @(posedge clk);
            load <= 1'b0;
            @(negedge clk);
            `CHK("main_irq", src, m_irq)
            `CHK("sec_irq", {4'h0, src[37], 3'h0}, s_irq)
            `CHK("main_nmi", src[5], m_nmi)
            `CHK("sec_nmi", src[9], s_nmi)
            `CHK("main_wake", m_slp & src[38], m_wake)
            `CHK("sec_wake", s_slp & src[0], s_wake)
        end
        $display("test sources done");
        idx <= 8'hA7;
        wb(1'b1, 12'h00C, 32'h0000_00A5);
        wb(1'b1, 12'h010, 32'hC000_0003);
        wb(1'b1, 12'h69C, 32'h0000_0007);
        @(posedge clk);
        @(negedge clk);
        `CHK("sec_swi", 8'hA5, s_swi)
        `CHK("sec_prio", 32'hC000_0003, s_prio)
        `CHK("main_prio", 3'h7, m_prio)
        rdchk("unmapped", 12'h0F0, 32'h0000_0000);
        $display("test config done");
        // Channel and structure 14 only: the low ones are left to the system
        rdchk("acq_free", 12'h278, 32'h0000_0001);
        rdchk("acq_busy", 12'h278, 32'h0000_0000);
        rdchk("lock", 12'h030, 32'h0000_4000);
        wb(1'b1, 12'h008, 32'h0000_0001);
        @(negedge clk);
        `CHK("int_set", 1'b1, int_o)
        wb(1'b1, 12'h004, 32'h0000_0001);
        @(negedge clk);
        `CHK("int_clr", 1'b0, int_o)
        wb(1'b1, 12'h374, 32'h4000_4000);
        wb(1'b1, 12'h2B8, 32'h0000_4000);
        @(negedge clk);
        `CHK("ipc_rel", 16'h4000, interproc_channel_block)
        rdchk("unlock", 12'h030, 32'h0000_0000);
        wb(1'b1, 12'h2F8, 32'h0000_4000);
        @(negedge clk);
        `CHK("ipc_note", 16'h4000, interproc_channel_block)
        rdchk("note", 12'h370, 32'h4000_4000);
        $display("test channels done");
        finish_test();
    end
endmodule
